// File: hw/vtd_pkg.sv
// Purpose: shared constants and types for the voltage trip detect control block
// Assumes: 100 MHz system clock, byte-wide register port
// Notes: register offsets are word indices on the plain register port
package vtd_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_MASTER = 4'h1;
  localparam logic [3:0] OFS_FLAGS = 4'h2;
  localparam logic [3:0] OFS_ENABLES = 4'h3;
  localparam logic [3:0] OFS_PRIORITIES = 4'h4;

  // control register fields
  localparam int unsigned CTL_DIR_BIT = 7;
  localparam int unsigned CTL_BGS_BIT = 6;
  localparam int unsigned CTL_RSTB_BIT = 5;
  localparam int unsigned CTL_EN_BIT = 4;
  localparam int unsigned CTL_LVL_MSB = 3;
  localparam int unsigned CTL_LVL_LSB = 0;
  localparam logic [3:0] LVL_EXTERNAL = 4'hf;
  localparam logic [3:0] LVL_RESET = 4'h4;
  localparam int unsigned LVL_COUNT = 16;

  // flag / enable / priority bit of the trip event, global enable bit
  localparam int unsigned TRIP_BIT = 2;
  localparam int unsigned GIE_BIT = 7;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] MASTER_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] PRIORITIES_RESET = 8'h00;

  // reference settle time and its cycle count, rounded up (a least time)
  localparam int unsigned SETTLE_NS = 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SETTLE_W = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } vtd_bus_s;

  typedef struct packed {
    logic dir;
    logic en;
    logic [3:0] lvl;
  } vtd_cfg_s;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_SETTLE = 3'b010,
    ST_ARMED = 3'b100
  } vtd_state_e;

  function automatic logic vtd_hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction
endpackage

// File: hw/vtd_sync.sv
// Purpose: two-stage synchroniser for the comparator level
// Assumes: input asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module vtd_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule

// File: hw/vtd_settle.sv
// Purpose: reference settle timer, counts from enable to stable
// Assumes: fixed time constant, so the interval does not follow software clock settings
// Notes: restarts whenever the detector is disabled
`timescale 1ns/1ps
module vtd_settle (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  output logic stable
);
  localparam logic [7:0] LAST = 8'(vtd_pkg::SETTLE_CYC - 1);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_stable;

  always_comb begin
    next_cnt = cnt;
    next_stable = stable;
    if (!enable) begin
      next_cnt = 8'h00;
      next_stable = 1'b0;
    end else if (!stable) begin
      if (cnt == LAST) begin
        next_stable = 1'b1;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      stable <= 1'b0;
    end else begin
      cnt <= next_cnt;
      stable <= next_stable;
    end
  end
endmodule

// File: hw/vtd_top.sv
// Purpose: control, flag and wake logic around a supply voltage trip comparator
// Assumes: comparator result is high while the monitored voltage is above the trip point
// Notes: analog divider and reference live outside; this block drives the tap select
//
// Overview of operation
// - software picks one of sixteen trip points
// - level all ones selects external trip input
// - crossing in chosen direction sets trip flag
// - no flag until reference stable is set
// - settle time fixed, crossings then may be missed
// - detector runs in sleep and wakes device
// - vector only when global enable set
// - reset returns registers, detector disabled
// - direction one high detect, zero low
// - module active only while enable set
// - reference stable bit is read only status
// - cleared direction watches drop, set watches rise
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module vtd_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // analog side
  input wire logic comp_above,
  input wire logic bandgap_stable,
  output logic detector_enable,
  output logic [3:0] tap_select,
  output logic external_trip_input_sel,
  // system side
  input wire logic sleeping,
  output logic wake,
  output logic irq,
  output logic irq_vector
);
  vtd_pkg::vtd_bus_s bus;
  vtd_pkg::vtd_cfg_s cfg;
  vtd_pkg::vtd_cfg_s next_cfg;
  vtd_pkg::vtd_state_e state;
  vtd_pkg::vtd_state_e next_state;
  logic [7:0] master;
  logic [7:0] next_master;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [7:0] enables;
  logic [7:0] next_enables;
  logic [7:0] prios;
  logic [7:0] next_prios;
  logic [7:0] next_rdata;
  logic bg_stable;
  logic next_bg_stable;
  logic cmp_sync;
  logic cmp_prev;
  logic ref_stable;
  logic crossing;
  logic trip_set;
  logic next_irq;
  logic next_wake;
  logic next_vector;
  logic next_enable_out;
  logic [3:0] next_tap;
  logic next_ext;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  vtd_sync u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(comp_above),
    .sync_out(cmp_sync)
  );

  // timer is cleared by the enable, so each enable waits the full interval
  vtd_settle u_settle (
    .clk(clk),
    .rst(rst),
    .enable(cfg.en),
    .stable(ref_stable)
  );

  // state: off, settling, armed
  always_comb begin
    next_state = state;
    case (state)
      vtd_pkg::ST_OFF: begin
        if (cfg.en) begin
          next_state = vtd_pkg::ST_SETTLE;
        end
      end
      vtd_pkg::ST_SETTLE: begin
        if (!cfg.en) begin
          next_state = vtd_pkg::ST_OFF;
        end else if (ref_stable) begin
          next_state = vtd_pkg::ST_ARMED;
        end
      end
      vtd_pkg::ST_ARMED: begin
        if (!cfg.en) begin
          next_state = vtd_pkg::ST_OFF;
        end
      end
      default: begin
        next_state = vtd_pkg::ST_OFF;
      end
    endcase
  end

  // crossing: a rise with direction set, a drop with it cleared
  always_comb begin
    if (cfg.dir) begin
      crossing = cmp_sync && !cmp_prev;
    end else begin
      crossing = !cmp_sync && cmp_prev;
    end
    // excursions while settling are dropped
    trip_set = crossing && (state == vtd_pkg::ST_ARMED) && cfg.en;
  end

  // registers
  always_comb begin
    next_cfg = cfg;
    next_master = master;
    next_enables = enables;
    next_prios = prios;
    next_flags = flags;
    next_bg_stable = bandgap_stable;
    if (bus.wr) begin
      if (vtd_pkg::vtd_hit(bus.addr, vtd_pkg::OFS_CONTROL)) begin
        // status bits 6 and 5 ignore writes
        next_cfg.dir = bus.wdata[vtd_pkg::CTL_DIR_BIT];
        next_cfg.en = bus.wdata[vtd_pkg::CTL_EN_BIT];
        next_cfg.lvl = bus.wdata[vtd_pkg::CTL_LVL_MSB:vtd_pkg::CTL_LVL_LSB];
      end
      if (vtd_pkg::vtd_hit(bus.addr, vtd_pkg::OFS_MASTER)) begin
        next_master = bus.wdata;
      end
      if (vtd_pkg::vtd_hit(bus.addr, vtd_pkg::OFS_ENABLES)) begin
        next_enables = bus.wdata;
      end
      if (vtd_pkg::vtd_hit(bus.addr, vtd_pkg::OFS_PRIORITIES)) begin
        next_prios = bus.wdata;
      end
      if (vtd_pkg::vtd_hit(bus.addr, vtd_pkg::OFS_FLAGS)) begin
        next_flags = flags & ~bus.wdata;
      end
    end
    // set wins over a clear in the same cycle
    if (trip_set) begin
      next_flags[vtd_pkg::TRIP_BIT] = 1'b1;
    end
  end

  // read data and outputs
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        vtd_pkg::OFS_CONTROL: begin
          next_rdata = {cfg.dir, bg_stable, ref_stable, cfg.en, cfg.lvl};
        end
        vtd_pkg::OFS_MASTER: begin
          next_rdata = master;
        end
        vtd_pkg::OFS_FLAGS: begin
          next_rdata = flags;
        end
        vtd_pkg::OFS_ENABLES: begin
          next_rdata = enables;
        end
        vtd_pkg::OFS_PRIORITIES: begin
          next_rdata = prios;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
    next_enable_out = next_cfg.en;
    next_ext = next_cfg.en && (next_cfg.lvl == vtd_pkg::LVL_EXTERNAL);
    next_tap = next_cfg.lvl;
    next_irq = |(next_flags & next_enables);
    // wake from sleep needs only the local enable, vector also the global one
    next_wake = sleeping && next_irq;
    next_vector = next_irq && next_master[vtd_pkg::GIE_BIT];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= vtd_pkg::ST_OFF;
      cfg <= '{dir: 1'b0, en: 1'b0, lvl: vtd_pkg::LVL_RESET};
      master <= vtd_pkg::MASTER_RESET;
      flags <= vtd_pkg::FLAGS_RESET;
      enables <= vtd_pkg::ENABLES_RESET;
      prios <= vtd_pkg::PRIORITIES_RESET;
      bg_stable <= 1'b0;
      cmp_prev <= 1'b0;
      reg_rdata <= 8'h00;
      detector_enable <= 1'b0;
      tap_select <= vtd_pkg::LVL_RESET;
      external_trip_input_sel <= 1'b0;
      irq <= 1'b0;
      wake <= 1'b0;
      irq_vector <= 1'b0;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      master <= next_master;
      flags <= next_flags;
      enables <= next_enables;
      prios <= next_prios;
      bg_stable <= next_bg_stable;
      cmp_prev <= cmp_sync;
      reg_rdata <= next_rdata;
      detector_enable <= next_enable_out;
      tap_select <= next_tap;
      external_trip_input_sel <= next_ext;
      irq <= next_irq;
      wake <= next_wake;
      irq_vector <= next_vector;
    end
  end

  a_flag_needs_armed: assert property (@(posedge clk) disable iff (rst)
    $rose(flags[vtd_pkg::TRIP_BIT]) |-> $past(state) == vtd_pkg::ST_ARMED)
    else $error("trip flag set before reference stable");

  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    flags[vtd_pkg::TRIP_BIT] && !(bus.wr && bus.addr == vtd_pkg::OFS_FLAGS && bus.wdata[vtd_pkg::TRIP_BIT])
    |=> flags[vtd_pkg::TRIP_BIT])
    else $error("trip flag lost without clear");

  a_trip_sets_flag: assert property (@(posedge clk) disable iff (rst)
    trip_set |=> flags[vtd_pkg::TRIP_BIT])
    else $error("crossing did not set flag");

  a_low_dir_drop: assert property (@(posedge clk) disable iff (rst)
    state == vtd_pkg::ST_ARMED && cfg.en && !cfg.dir && !cmp_sync && cmp_prev |=> flags[vtd_pkg::TRIP_BIT])
    else $error("drop missed in low detect");

  a_high_dir_rise: assert property (@(posedge clk) disable iff (rst)
    state == vtd_pkg::ST_ARMED && cfg.en && cfg.dir && cmp_sync && !cmp_prev |=> flags[vtd_pkg::TRIP_BIT])
    else $error("rise missed in high detect");

  a_external_select: assert property (@(posedge clk) disable iff (rst)
    external_trip_input_sel |-> detector_enable && tap_select == vtd_pkg::LVL_EXTERNAL)
    else $error("external input selected wrongly");

  // the enable output is a registered copy of the enable bit, the state follows a cycle later
  a_enable_follows: assert property (@(posedge clk) disable iff (rst)
    !cfg.en |-> !detector_enable ##1 state != vtd_pkg::ST_ARMED)
    else $error("detector active while disabled");

  // a same-cycle write to the enables register decides, so look at its next value
  a_wake_sleep: assert property (@(posedge clk) disable iff (rst)
    sleeping && trip_set && next_enables[vtd_pkg::TRIP_BIT] |=> wake)
    else $error("no wake on trip in sleep");

  a_vector_gated: assert property (@(posedge clk) disable iff (rst)
    irq_vector |-> irq && $past(next_master[vtd_pkg::GIE_BIT]))
    else $error("vector without global enable");

  a_tap_follows: assert property (@(posedge clk) disable iff (rst)
    bus.wr && bus.addr == vtd_pkg::OFS_CONTROL
    |=> tap_select == $past(bus.wdata[vtd_pkg::CTL_LVL_MSB:vtd_pkg::CTL_LVL_LSB]))
    else $error("tap select not taken from level field");

  a_external_selected: assert property (@(posedge clk) disable iff (rst)
    detector_enable && tap_select == vtd_pkg::LVL_EXTERNAL |-> external_trip_input_sel)
    else $error("external input not selected");

  // stable may only rise once the enable has stood for the whole interval
  a_settle_time: assert property (@(posedge clk) disable iff (rst)
    $rose(ref_stable) |-> $past(cfg.en, vtd_pkg::SETTLE_CYC))
    else $error("reference stable too early");

  a_stable_readback: assert property (@(posedge clk) disable iff (rst)
    bus.rd && bus.addr == vtd_pkg::OFS_CONTROL |=> reg_rdata[vtd_pkg::CTL_RSTB_BIT] == $past(ref_stable))
    else $error("stable bit not shown on read");

  a_disable_unsettles: assert property (@(posedge clk) disable iff (rst)
    !cfg.en |=> !ref_stable)
    else $error("reference stable while disabled");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    (flags & enables) != 8'h00 && !bus.wr |=> irq)
    else $error("interrupt missing for enabled flag");

  a_awake_no_wake: assert property (@(posedge clk) disable iff (rst)
    !sleeping |=> !wake)
    else $error("wake raised while awake");

  // a clear only loses against a crossing in the same cycle
  a_clear_works: assert property (@(posedge clk) disable iff (rst)
    bus.wr && bus.addr == vtd_pkg::OFS_FLAGS && bus.wdata[vtd_pkg::TRIP_BIT] && !trip_set
    |=> !flags[vtd_pkg::TRIP_BIT])
    else $error("trip flag not cleared");

  // low detect must not react to a rise
  a_low_ignores_rise: assert property (@(posedge clk) disable iff (rst)
    cfg.en && !cfg.dir && cmp_sync && !cmp_prev && !flags[vtd_pkg::TRIP_BIT]
    |=> !flags[vtd_pkg::TRIP_BIT])
    else $error("rise tripped in low detect");
endmodule

// File: verif/vtd_comp_model.sv
// Purpose: behavioural comparator and reference behind the trip detector
// Assumes: trip point of tap n is 16n+8 on the bench voltage scale
// Notes: comparator reads low while unpowered, as the analog side is off
`timescale 1ns/1ps
module vtd_comp_model (
  // control from the detector
  input wire logic detector_enable,
  input wire logic [3:0] tap_select,
  input wire logic external_trip_input_sel,
  // bench stimulus
  input wire logic [7:0] vdd,
  input wire logic ext_above,
  // analog results
  output logic comp_above,
  output logic bandgap_stable
);
  initial bandgap_stable = 1'b0;
  always @(negedge detector_enable) bandgap_stable = 1'b0;
  // settling is absolute time, so it does not scale with the clock
  always @(posedge detector_enable) begin
    // off the clock edge so the design samples it without a race
    #303;
    bandgap_stable = detector_enable;
  end
  always_comb begin
    if (!detector_enable) comp_above = 1'b0;
    else if (external_trip_input_sel) comp_above = ext_above;
    else comp_above = vdd >= {tap_select, 4'h8};
  end
endmodule

// File: verif/vtd_tb_top.sv
// Purpose: self-checking bench for the trip detector control block
// Assumes: comparator model stands in for the analog divider and reference
// Notes: control bit 6 follows the model's reference and is masked where it may still be settling
`timescale 1ns/1ps
module vtd_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleeping = 1'b0;
  logic ext_above = 1'b1;
  logic [7:0] vdd = 8'hff;
  logic [7:0] reg_rdata;
  logic [3:0] tap_select;
  logic comp_above, bandgap_stable, detector_enable, external_trip_input_sel, wake, irq, irq_vector;
  logic [31:0] rng = 32'd32947;
  logic [7:0] rv;
  logic [3:0] lvl;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  vtd_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_above(comp_above), .bandgap_stable(bandgap_stable),
    .detector_enable(detector_enable), .tap_select(tap_select), .external_trip_input_sel(external_trip_input_sel),
    .sleeping(sleeping), .wake(wake), .irq(irq), .irq_vector(irq_vector));
  vtd_comp_model model_u (.detector_enable(detector_enable), .tap_select(tap_select),
    .external_trip_input_sel(external_trip_input_sel), .vdd(vdd), .ext_above(ext_above),
    .comp_above(comp_above), .bandgap_stable(bandgap_stable));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] ctl(input logic d, input logic e, input logic [3:0] l);
    return {d, 2'b00, e, l};
  endfunction
  function automatic logic [7:0] thr(input logic [3:0] l);
    return {l, 4'h8};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic flag_is(input logic f);
    repeat (6) @(posedge clk);
    rd(vtd_pkg::OFS_FLAGS, rv);
    check(rv, {5'h00, f, 2'b00});
  endtask
  // level and direction change only while off, so no false event appears
  task automatic setup(input logic d, input logic [3:0] l);
    wr(vtd_pkg::OFS_CONTROL, ctl(d, 1'b0, l));
    wr(vtd_pkg::OFS_CONTROL, ctl(d, 1'b1, l));
    wr(vtd_pkg::OFS_FLAGS, 8'h04);
  endtask
  task automatic pick;
    rng = xs(rng);
    lvl = (rng[3:0] == 4'hf) ? 4'he : rng[3:0];
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(vtd_pkg::OFS_CONTROL, rv);
    check(rv & 8'hbf, vtd_pkg::CONTROL_RESET);
    check({4'h0, tap_select}, {4'h0, vtd_pkg::LVL_RESET});
    check({7'h00, detector_enable}, 8'h00);
    for (int a = 1; a < 16; a++) begin
      rd(a[3:0], rv);
      check(rv, 8'h00);
    end
    rng = xs(rng);
    wr(vtd_pkg::OFS_PRIORITIES, rng[7:0]);
    rd(vtd_pkg::OFS_PRIORITIES, rv);
    check(rv, rng[7:0]);
    wr(4'hc, 8'hff);
    rd(4'hc, rv);
    check(rv, 8'h00);
    wr(vtd_pkg::OFS_CONTROL, 8'h63);
    rd(vtd_pkg::OFS_CONTROL, rv);
    check(rv, 8'h03);
    // low direction: a drop while settling is lost, a later drop trips
    pick();
    vdd <= thr(lvl) + 8'h04;
    setup(1'b0, lvl);
    check({4'h0, tap_select}, {4'h0, lvl});
    check({7'h00, external_trip_input_sel}, 8'h00);
    vdd <= thr(lvl) - 8'h04;
    repeat (20) @(posedge clk);
    rd(vtd_pkg::OFS_CONTROL, rv);
    check(rv & 8'hbf, ctl(1'b0, 1'b1, lvl));
    vdd <= thr(lvl) + 8'h04;
    repeat (vtd_pkg::SETTLE_CYC) @(posedge clk);
    rd(vtd_pkg::OFS_CONTROL, rv);
    check(rv, ctl(1'b0, 1'b1, lvl) | 8'h60);
    flag_is(1'b0);
    vdd <= thr(lvl) - 8'h04;
    flag_is(1'b1);
    wr(vtd_pkg::OFS_ENABLES, 8'h04);
    repeat (2) @(posedge clk);
    check({6'h00, irq, irq_vector}, 8'h02);
    wr(vtd_pkg::OFS_ENABLES, 8'h00);
    repeat (2) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    wr(vtd_pkg::OFS_FLAGS, 8'h04);
    flag_is(1'b0);
    // high direction while asleep wakes the device
    wr(vtd_pkg::OFS_ENABLES, 8'h04);
    wr(vtd_pkg::OFS_MASTER, 8'h80);
    sleeping <= 1'b1;
    pick();
    vdd <= thr(lvl) - 8'h04;
    setup(1'b1, lvl);
    repeat (vtd_pkg::SETTLE_CYC + 5) @(posedge clk);
    check({7'h00, wake}, 8'h00);
    vdd <= thr(lvl) + 8'h04;
    flag_is(1'b1);
    check({6'h00, wake, irq_vector}, 8'h03);
    wr(vtd_pkg::OFS_MASTER, 8'h00);
    repeat (2) @(posedge clk);
    check({6'h00, wake, irq_vector}, 8'h02);
    sleeping <= 1'b0;
    // external input selected by the all-ones level
    ext_above <= 1'b1;
    setup(1'b0, vtd_pkg::LVL_EXTERNAL);
    check({7'h00, external_trip_input_sel}, 8'h01);
    repeat (vtd_pkg::SETTLE_CYC + 5) @(posedge clk);
    ext_above <= 1'b0;
    flag_is(1'b1);
    wr(vtd_pkg::OFS_CONTROL, 8'h0f);
    rd(vtd_pkg::OFS_CONTROL, rv);
    check(rv & 8'hbf, 8'h0f);
    check({7'h00, detector_enable}, 8'h00);
    // reset in mid-run with state pending
    wr(vtd_pkg::OFS_MASTER, 8'h80);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(vtd_pkg::OFS_CONTROL, rv);
    check(rv & 8'hbf, vtd_pkg::CONTROL_RESET);
    rd(vtd_pkg::OFS_FLAGS, rv);
    check(rv, 8'h00);
    rd(vtd_pkg::OFS_MASTER, rv);
    check({rv[7:1], irq}, 8'h00);
    report_and_stop();
  end
endmodule
